// ---- verilog/ppio_pkg.sv ----
package ppio_pkg;
   localparam int         PPIO_DW    = 8;
   localparam int         PPIO_AW    = 5;
   // register indices; byte address is four times the index
   localparam logic [2:0] IDX_PA     = 3'h0;
   localparam logic [2:0] IDX_PB     = 3'h1;
   localparam logic [2:0] IDX_PC     = 3'h2;
   localparam logic [2:0] IDX_CTL    = 3'h3;
   localparam logic [7:0] CW_RESET   = 8'h9B;
   localparam logic [7:0] LAT_RESET  = 8'h00;
   // control word fields
   localparam int         CW_MODE    = 7;
   localparam int         CW_AM_HI   = 6;
   localparam int         CW_AM_LO   = 5;
   localparam int         CW_A_IN    = 4;
   localparam int         CW_CU_IN   = 3;
   localparam int         CW_B_MODE  = 2;
   localparam int         CW_B_IN    = 1;
   localparam int         CW_CL_IN   = 0;
   localparam int         CW_SEL_HI  = 3;
   localparam int         CW_SEL_LO  = 1;
   localparam int         CW_VAL     = 0;
   // port c handshake line positions
   localparam int         PC_INTR_B  = 0;
   localparam int         PC_HS_B    = 1;
   localparam int         PC_STB_B   = 2;
   localparam int         PC_INTR_A  = 3;
   localparam int         PC_STB_A   = 4;
   localparam int         PC_IBF_A   = 5;
   localparam int         PC_ACK_A   = 6;
   localparam int         PC_OBF_A   = 7;
   // port c lines owned and driven by each handshake group
   localparam logic [7:0] OWN_A_IN   = 8'h38;
   localparam logic [7:0] OWN_A_OUT  = 8'hC8;
   localparam logic [7:0] OWN_A_BI   = 8'hF8;
   localparam logic [7:0] OWN_B      = 8'h07;
   localparam logic [7:0] DRV_A_IN   = 8'h28;
   localparam logic [7:0] DRV_A_OUT  = 8'h88;
   localparam logic [7:0] DRV_A_BI   = 8'hA8;
   localparam logic [7:0] DRV_B      = 8'h03;
   typedef enum logic [1:0] {PPIO_BASIC, PPIO_STROBED, PPIO_BIDIR}
      ppio_mode_t;
endpackage

// ---- verilog/ppio_hs.sv ----
`timescale 1ns/10ps
// one handshake group: strobed input latch and strobed output flag
module ppio_hs
   import ppio_pkg::*;
#(
   parameter int W = PPIO_DW
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         clr,
   input  wire logic         in_en,
   input  wire logic         out_en,
   input  wire logic         stb_n,
   input  wire logic         ack_n,
   input  wire logic         inte_in,
   input  wire logic         inte_out,
   input  wire logic [W-1:0] din,
   input  wire logic         rd,
   input  wire logic         wr,
   output logic              ibf,
   output logic              obf,
   output logic              intr,
   output logic [W-1:0]      din_lat
);
   logic stb_q;
   logic ack_q;
   logic oack;
   logic stb_fall;
   logic ack_fall;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stb_q <= 1'b1;
         ack_q <= 1'b1;
      end else begin
         stb_q <= stb_n;
         ack_q <= ack_n;
      end
   end

   assign stb_fall = stb_q & ~stb_n;
   assign ack_fall = ack_q & ~ack_n;

   // data follows the pins while strobe is low and holds after it rises
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         din_lat <= '0;
      end else if (in_en && !stb_n) begin
         din_lat <= din;
      end
   end

   // a strobe in the same cycle as the read leaves the buffer full
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ibf <= 1'b0;
      end else if (clr) begin
         ibf <= 1'b0;
      end else if (in_en && stb_fall) begin
         ibf <= 1'b1;
      end else if (rd) begin
         ibf <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         obf <= 1'b0;
      end else if (clr) begin
         obf <= 1'b0;
      end else if (out_en && wr) begin
         obf <= 1'b1;
      end else if (ack_fall) begin
         obf <= 1'b0;
      end
   end

   // remembers that the partner took the last output byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         oack <= 1'b0;
      end else if (clr || wr) begin
         oack <= 1'b0;
      end else if (out_en && obf && ack_fall) begin
         oack <= 1'b1;
      end
   end

   assign intr = (in_en & inte_in & ibf & stb_n)
               | (out_en & inte_out & oack & ack_n);
endmodule

// ---- verilog/ppio_top.sv ----
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - basic mode: ports a, b byte wide, port c two nibbles, each in or out
// - basic outputs hold written values; basic inputs read the live pins
// - basic transfers are plain register accesses without handshake lines
// - group a and group b may run in different modes at once
// - strobed mode: each group is a byte port plus three port c lines
// - strobed handshake lines for both groups come from port c
// - strobed byte ports may be input or output, latched either way
// - strobed groups raise an interrupt request gated by a software enable
// - bidirectional mode only on group a, five port c lines, latched
// - one control write sets or clears a single port c bit
// - the port c bit set/clear drives the handshake enables
// - control word with bit 7 set selects modes, else bit set/clear
// - basic mode: bits 4, 3, 1, 0 make a, c upper, b, c lower inputs
// - bits 7, 2, 1 set make port b a strobed input
// - with port a strobed input, port c lines 6, 7 stay general
// - both groups strobed leave no spare port c line for group b
// - port c read shows handshake lines and interrupt flags
// - port c bit 5 reads high while the port a input latch is full
// - group a interrupt enable follows port c line 4 set/clear
// - group a request only while enabled and input data is waiting, or while the output enable is set and the output byte was taken
module ppio_top
   import ppio_pkg::*;
#(
   parameter int W = PPIO_DW
) (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic [PPIO_AW-1:0] avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest,
   input  wire logic [W-1:0]       pa_in,
   output logic      [W-1:0]       pa_out,
   output logic      [W-1:0]       pa_oe_n,
   input  wire logic [W-1:0]       pb_in,
   output logic      [W-1:0]       pb_out,
   output logic      [W-1:0]       pb_oe_n,
   input  wire logic [7:0]         pc_in,
   output logic      [7:0]         pc_out,
   output logic      [7:0]         pc_oe_n,
   output logic                    group_a_irq_request,
   output logic                    group_b_irq_request
);
   if (W < 1 || W > PPIO_DW) begin : g_bad_width
      $error("ppio_top: W must lie between 1 and 8");
   end

   logic [1:0]   rst_sync;
   logic         rst;
   logic         ack;
   logic         wr_en;
   logic         rd_en;
   logic [2:0]   idx;
   logic [7:0]   wbyte;
   logic [7:0]   cw;
   logic [W-1:0] pa_lat;
   logic [W-1:0] pb_lat;
   logic [7:0]   pc_lat;
   ppio_mode_t   amode;
   logic         b_str;
   logic         a_in;
   logic         b_in;
   logic         mode_wr;
   logic         bit_wr;
   logic         wr_a;
   logic         wr_b;
   logic         rd_a;
   logic         rd_b;
   logic         ibf_a;
   logic         obf_a;
   logic         intr_a;
   logic         ibf_b;
   logic         obf_b;
   logic         intr_b;
   logic [W-1:0] a_ilat;
   logic [W-1:0] b_ilat;
   logic [7:0]   own;
   logic [7:0]   drv;
   logic [7:0]   sts;
   logic [7:0]   gen_in;
   logic [7:0]   pc_rd;
   logic [7:0]   rd8;
   logic         group_a_irq_enable;
   logic [7:0]   next_pc_out;
   logic [7:0]   next_pc_oe_n;
   logic [W-1:0] next_pa_oe_n;
   logic [W-1:0] next_pb_oe_n;

   function automatic ppio_mode_t dec_amode(input logic [1:0] f);
      if (f[1]) begin
         return PPIO_BIDIR;
      end else if (f[0]) begin
         return PPIO_STROBED;
      end
      return PPIO_BASIC;
   endfunction

   function automatic logic [7:0] port_rd(input logic         strobed,
                                          input logic         is_in,
                                          input logic [W-1:0] live,
                                          input logic [W-1:0] olat,
                                          input logic [W-1:0] ilat);
      logic [W-1:0] v;
      if (!strobed) begin
         v = is_in ? live : olat;
      end else begin
         v = is_in ? ilat : olat;
      end
      return 8'(v);
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst = rst_sync[1];

   // one wait state: read data is registered before waitrequest drops
   always_ff @(posedge clk or negedge rst) begin
      if (!rst) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read | avs_write) & ~ack;
      end
   end
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign idx     = avs_address[PPIO_AW-1:2];
   assign wbyte   = avs_writedata[7:0];
   assign wr_en   = avs_write & ack & avs_byteenable[0];
   assign rd_en   = avs_read & ack;
   assign mode_wr = wr_en & (idx == IDX_CTL) & wbyte[CW_MODE];
   assign bit_wr  = wr_en & (idx == IDX_CTL) & ~wbyte[CW_MODE];
   assign wr_a    = wr_en & (idx == IDX_PA);
   assign wr_b    = wr_en & (idx == IDX_PB);
   assign rd_a    = rd_en & (idx == IDX_PA);
   assign rd_b    = rd_en & (idx == IDX_PB);

   always_ff @(posedge clk or negedge rst) begin
      if (!rst) begin
         cw <= CW_RESET;
      end else if (mode_wr) begin
         cw <= wbyte;
      end
   end

   // group modes decode independently of each other
   assign amode = dec_amode(cw[CW_AM_HI:CW_AM_LO]);
   assign b_str = cw[CW_B_MODE];
   assign a_in  = cw[CW_A_IN] | (amode == PPIO_BIDIR);
   assign b_in  = cw[CW_B_IN];

   // output latches clear on every mode change
   always_ff @(posedge clk or negedge rst) begin
      if (!rst) begin
         pa_lat <= W'(LAT_RESET);
      end else if (mode_wr) begin
         pa_lat <= W'(LAT_RESET);
      end else if (wr_a) begin
         pa_lat <= avs_writedata[W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst) begin
      if (!rst) begin
         pb_lat <= W'(LAT_RESET);
      end else if (mode_wr) begin
         pb_lat <= W'(LAT_RESET);
      end else if (wr_b) begin
         pb_lat <= avs_writedata[W-1:0];
      end
   end

   // the interrupt enables live in the port c latch itself
   always_ff @(posedge clk or negedge rst) begin
      if (!rst) begin
         pc_lat <= LAT_RESET;
      end else if (mode_wr) begin
         pc_lat <= LAT_RESET;
      end else if (bit_wr) begin
         pc_lat[wbyte[CW_SEL_HI:CW_SEL_LO]] <= wbyte[CW_VAL];
      end else if (wr_en && idx == IDX_PC) begin
         pc_lat <= wbyte;
      end
   end
   assign group_a_irq_enable = pc_lat[PC_STB_A];

   ppio_hs #(
      .W (W)
   ) u_hs_a (
      .clk      (clk),
      .rst_n    (rst),
      .clr      (mode_wr),
      .in_en    ((amode != PPIO_BASIC) & a_in),
      .out_en   ((amode == PPIO_BIDIR) | (amode == PPIO_STROBED & ~a_in)),
      .stb_n    (pc_in[PC_STB_A]),
      .ack_n    (pc_in[PC_ACK_A]),
      .inte_in  (group_a_irq_enable),
      .inte_out (pc_lat[PC_ACK_A]),
      .din      (pa_in),
      .rd       (rd_a),
      .wr       (wr_a),
      .ibf      (ibf_a),
      .obf      (obf_a),
      .intr     (intr_a),
      .din_lat  (a_ilat)
   );

   ppio_hs #(
      .W (W)
   ) u_hs_b (
      .clk      (clk),
      .rst_n    (rst),
      .clr      (mode_wr),
      .in_en    (b_str & b_in),
      .out_en   (b_str & ~b_in),
      .stb_n    (pc_in[PC_STB_B]),
      .ack_n    (pc_in[PC_STB_B]),
      .inte_in  (pc_lat[PC_STB_B]),
      .inte_out (pc_lat[PC_STB_B]),
      .din      (pb_in),
      .rd       (rd_b),
      .wr       (wr_b),
      .ibf      (ibf_b),
      .obf      (obf_b),
      .intr     (intr_b),
      .din_lat  (b_ilat)
   );

   assign group_a_irq_request = intr_a;
   assign group_b_irq_request = intr_b;

   // port c: handshake lines per group, the rest general nibble io
   always_comb begin
      own = 8'h00;
      drv = 8'h00;
      case (amode)
         PPIO_STROBED: begin
            own = a_in ? OWN_A_IN : OWN_A_OUT;
            drv = a_in ? DRV_A_IN : DRV_A_OUT;
         end
         PPIO_BIDIR: begin
            own = OWN_A_BI;
            drv = DRV_A_BI;
         end
         default: begin
            own = 8'h00;
            drv = 8'h00;
         end
      endcase
      if (b_str) begin
         own = own | OWN_B;
         drv = drv | DRV_B;
      end
   end

   always_comb begin
      sts            = 8'h00;
      sts[PC_OBF_A]  = ~obf_a;
      sts[PC_ACK_A]  = pc_lat[PC_ACK_A];
      sts[PC_IBF_A]  = ibf_a;
      sts[PC_STB_A]  = group_a_irq_enable;
      sts[PC_INTR_A] = intr_a;
      sts[PC_STB_B]  = pc_lat[PC_STB_B];
      sts[PC_HS_B]   = b_in ? ibf_b : ~obf_b;
      sts[PC_INTR_B] = intr_b;
   end

   assign gen_in = {{4{cw[CW_CU_IN]}}, {4{cw[CW_CL_IN]}}};
   assign pc_rd  = (sts & own)
                 | (~own & ((gen_in & pc_in) | (~gen_in & pc_lat)));
   assign next_pc_out  = (sts & drv) | (pc_lat & ~drv);
   assign next_pc_oe_n = ~(drv | (~own & ~gen_in));

   // in bidirectional mode port a drives only while ack is held low
   always_comb begin
      next_pa_oe_n = {W{a_in}};
      if (amode == PPIO_BIDIR) begin
         next_pa_oe_n = {W{pc_in[PC_ACK_A]}};
      end
   end
   assign next_pb_oe_n = {W{b_in}};

   always_ff @(posedge clk or negedge rst) begin
      if (!rst) begin
         pc_out  <= LAT_RESET;
         pc_oe_n <= 8'hFF;
         pa_oe_n <= '1;
         pb_oe_n <= '1;
      end else begin
         pc_out  <= next_pc_out;
         pc_oe_n <= next_pc_oe_n;
         pa_oe_n <= next_pa_oe_n;
         pb_oe_n <= next_pb_oe_n;
      end
   end
   assign pa_out = pa_lat;
   assign pb_out = pb_lat;

   always_comb begin
      case (idx)
         IDX_PA:  rd8 = port_rd(amode != PPIO_BASIC, a_in, pa_in, pa_lat,
                                a_ilat);
         IDX_PB:  rd8 = port_rd(b_str, b_in, pb_in, pb_lat, b_ilat);
         IDX_PC:  rd8 = pc_rd;
         IDX_CTL: rd8 = cw;
         default: rd8 = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst) begin
      if (!rst) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && !ack) begin
         avs_readdata <= {24'h000000, rd8};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst);

   chk_wait_one: assert property (
      (avs_read || avs_write) && !ack |=> !avs_waitrequest)
      else $error("waitrequest not released after one wait state");
   chk_live_read: assert property (
      avs_read && !ack && idx == IDX_PA && amode == PPIO_BASIC && a_in
      |=> avs_readdata[W-1:0] == $past(pa_in))
      else $error("basic input read did not return live pins");
   chk_out_hold: assert property (
      !wr_a && !mode_wr |=> pa_out == $past(pa_out))
      else $error("port a output latch changed without a write");
   chk_mode_word: assert property (
      mode_wr |=> cw == $past(wbyte))
      else $error("mode word not stored");
   chk_bit_only: assert property (
      bit_wr |=> pc_lat[$past(wbyte[CW_SEL_HI:CW_SEL_LO])]
                 == $past(wbyte[CW_VAL])
              && $countones(pc_lat ^ $past(pc_lat)) <= 1)
      else $error("bit set/clear touched more than one bit");
   chk_b_strobe_in: assert property (
      mode_wr && wbyte[CW_B_MODE] && wbyte[CW_B_IN]
      |=> b_str && b_in && (own & OWN_B) == OWN_B)
      else $error("port b not strobed input");
   chk_a_strobe_in: assert property (
      mode_wr && wbyte[CW_AM_HI:CW_AM_LO] == 2'h1 && wbyte[CW_A_IN]
      |=> amode == PPIO_STROBED && own[PC_ACK_A] == 1'b0
          && own[PC_OBF_A] == 1'b0)
      else $error("port a strobed input misdecoded or lines 6, 7 taken");
   chk_ibf_set: assert property (
      amode == PPIO_STROBED && a_in && !mode_wr && !rd_a
      && $fell(pc_in[PC_STB_A]) |-> ##1 pc_rd[PC_IBF_A])
      else $error("input buffer full not shown after strobe");
   chk_irq_gate: assert property (
      amode == PPIO_STROBED && a_in && group_a_irq_request
      |-> group_a_irq_enable && ibf_a)
      else $error("group a request without enable or data");
   chk_basic_dir: assert property (
      amode == PPIO_BASIC && $stable(cw)
      |=> pa_oe_n == {W{$past(cw[CW_A_IN])}}
      && pc_oe_n[7:4] == {4{$past(cw[CW_CU_IN])}})
      else $error("basic mode direction decode wrong");

   cov_basic_in: cover property (
      avs_read && ack && idx == IDX_PA && amode == PPIO_BASIC);
   cov_strobe_in: cover property (
      amode == PPIO_STROBED && ibf_a ##[1:20] rd_a);
   cov_irq_a: cover property (group_a_irq_request);
   cov_bidir: cover property (amode == PPIO_BIDIR && !pa_oe_n[0]);
endmodule

// ---- dv/ppio_peer.sv ----
`timescale 1ns/10ps
// far-side parallel equipment: drives every pin the device leaves free
module ppio_peer
   import ppio_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] pc_pin,
   output logic      [7:0] pa_drv,
   output logic      [7:0] pb_drv,
   output logic      [7:0] pc_drv
);
   initial begin
      pa_drv = 8'h00;
      pb_drv = 8'h00;
      pc_drv = 8'hFF;
   end

   task automatic set_pins(input logic [7:0] a,
                           input logic [7:0] b,
                           input logic [7:0] c);
      @(posedge clk);
      pa_drv <= a;
      pb_drv <= b;
      pc_drv <= c;
   endtask

   // one strobed byte into group a, or group b when is_b is set
   task automatic send(input logic is_b, input logic [7:0] d);
      int stb;
      int full;
      int n;
      stb = is_b ? PC_STB_B : PC_STB_A;
      full = is_b ? PC_HS_B : PC_IBF_A;
      n = 0;
      while (pc_pin[full] !== 1'b0 && n < 500) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      if (is_b) pb_drv <= d;
      else pa_drv <= d;
      @(posedge clk);
      pc_drv[stb] <= 1'b0;
      repeat (2) @(posedge clk);
      pc_drv[stb] <= 1'b1;
      @(posedge clk);
      // hold time over: show the inverse so a late sample is caught
      if (is_b) pb_drv <= ~d;
      else pa_drv <= ~d;
   endtask

   // acknowledge one output byte on the group a ack line
   task automatic take();
      @(posedge clk);
      pc_drv[PC_ACK_A] <= 1'b0;
      repeat (2) @(posedge clk);
      pc_drv[PC_ACK_A] <= 1'b1;
   endtask
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
module testbench
   import ppio_pkg::*;
;
   logic               clk;
   logic               rst_n;
   logic [PPIO_AW-1:0] avs_address;
   logic               avs_read;
   logic               avs_write;
   logic [31:0]        avs_writedata;
   logic [3:0]         avs_byteenable;
   logic [31:0]        avs_readdata;
   logic               avs_waitrequest;
   logic [7:0]         pa_in, pa_out, pa_oe_n, pa_drv;
   logic [7:0]         pb_in, pb_out, pb_oe_n, pb_drv;
   logic [7:0]         pc_in, pc_out, pc_oe_n, pc_drv;
   logic               group_a_irq_request;
   logic               group_b_irq_request;
   int                 num_errors;
   int                 checked;
   logic [7:0]         cw, a, b, c, ma, mb, mc, d, exp_c, dump;

   // wire level: device where it drives, far side elsewhere
   assign pa_in = (pa_out & ~pa_oe_n) | (pa_drv & pa_oe_n);
   assign pb_in = (pb_out & ~pb_oe_n) | (pb_drv & pb_oe_n);
   assign pc_in = (pc_out & ~pc_oe_n) | (pc_drv & pc_oe_n);

   ppio_top #(.W(8)) DUT (
      .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
      .pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n),
      .pc_in(pc_in), .pc_out(pc_out), .pc_oe_n(pc_oe_n),
      .group_a_irq_request(group_a_irq_request),
      .group_b_irq_request(group_b_irq_request));

   ppio_peer peer (
      .clk(clk), .pc_pin(pc_in), .pa_drv(pa_drv), .pb_drv(pb_drv),
      .pc_drv(pc_drv));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic finish_test();
      if (num_errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic compare(input string name, input logic [7:0] exp,
                          input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [2:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {24'h0, wd};
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      if (n >= 100) compare("bus answer", 8'h00, 8'h01);
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr_reg(input logic [2:0] idx, input logic [7:0] wd);
      logic [7:0] r;
      bus(1'b1, idx, wd, r);
   endtask

   task automatic rd_chk(input string name, input logic [2:0] idx,
                         input logic [7:0] exp);
      logic [7:0] r;
      bus(1'b0, idx, 8'h00, r);
      compare(name, exp, r);
   endtask

   task automatic wait_pc(input int bi);
      int n;
      n = 0;
      while (pc_in[bi] !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      repeat (3) @(posedge clk);
      compare("buffer full", 8'h01, {7'h0, pc_in[bi]});
   endtask

   // input bits show the pin, output bits the written latch
   function automatic logic [7:0] pick(logic [7:0] m, logic [7:0] lat,
                                       logic [7:0] pin);
      return (m & pin) | (~m & lat);
   endfunction

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      finish_test();
   end

   initial begin
      num_errors = 0;
      checked = 0;
      rst_n = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = 4'hF;
      void'($urandom(94));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      compare("reset oe a", 8'hFF, pa_oe_n);
      rd_chk("reset ctl", IDX_CTL, CW_RESET);
      for (int k = 0; k < 16; k++) begin
         cw = 8'h80 | {3'h0, k[3], k[2], 1'b0, k[1], k[0]};
         wr_reg(IDX_CTL, cw);
         repeat (2) @(posedge clk);
         compare("pa_out cleared", 8'h00, pa_out);
         ma = {8{k[3]}};
         mb = {8{k[1]}};
         mc = {{4{k[2]}}, {4{k[0]}}};
         a = 8'($urandom);
         b = 8'($urandom);
         c = 8'($urandom);
         wr_reg(IDX_PA, a);
         wr_reg(IDX_PB, b);
         wr_reg(IDX_PC, c);
         d = 8'($urandom);
         exp_c = 8'($urandom);
         dump = 8'($urandom);
         peer.set_pins(d, exp_c, dump);
         repeat (2) @(posedge clk);
         compare("pa_oe_n", ma, pa_oe_n);
         compare("pb_oe_n", mb, pb_oe_n);
         compare("pc_oe_n", mc, pc_oe_n);
         compare("pb_out", b, pb_out);
         rd_chk("port a", IDX_PA, pick(ma, a, d));
         rd_chk("port b", IDX_PB, pick(mb, b, exp_c));
         rd_chk("port c", IDX_PC, pick(mc, c, dump));
      end
      wr_reg(IDX_CTL, 8'h80);
      avs_byteenable <= 4'hE;
      wr_reg(IDX_PA, 8'h5A);
      avs_byteenable <= 4'hF;
      rd_chk("masked write", IDX_PA, 8'h00);
      rd_chk("unmapped", 3'h5, 8'h00);
      exp_c = 8'h00;
      for (int i = 0; i < 16; i++) begin
         a = 8'($urandom);
         wr_reg(IDX_CTL, {4'h0, a[3:1], a[0]});
         exp_c[a[3:1]] = a[0];
         repeat (2) @(posedge clk);
         compare("bit set clear", exp_c, pc_out);
      end
      rd_chk("ctl kept", IDX_CTL, 8'h80);
      // group a strobed input with lines 6 and 7 left general
      wr_reg(IDX_CTL, 8'hB0);
      wr_reg(IDX_CTL, 8'h09);
      wr_reg(IDX_CTL, 8'h0F);
      peer.set_pins(8'($urandom), 8'($urandom), 8'hFF);
      d = 8'($urandom);
      peer.send(1'b0, d);
      wait_pc(PC_IBF_A);
      compare("irq a", 8'h01, {7'h0, group_a_irq_request});
      compare("line 7", 8'h02, {6'h0, pc_out[7], pc_oe_n[7]});
      rd_chk("status a", IDX_PC, 8'hB8);
      rd_chk("latched a", IDX_PA, d);
      repeat (3) @(posedge clk);
      compare("irq a off", 8'h00, {7'h0, group_a_irq_request});
      compare("full a off", 8'h00, {7'h0, pc_out[5]});
      wr_reg(IDX_CTL, 8'h08);
      d = 8'($urandom);
      peer.send(1'b0, d);
      wait_pc(PC_IBF_A);
      compare("irq gated", 8'h00, {7'h0, group_a_irq_request});
      rd_chk("latched a2", IDX_PA, d);
      // both groups strobed, group b traffic first
      wr_reg(IDX_CTL, 8'hB6);
      wr_reg(IDX_CTL, 8'h05);
      wr_reg(IDX_CTL, 8'h09);
      d = 8'($urandom);
      peer.send(1'b1, d);
      wait_pc(PC_HS_B);
      compare("irq b", 8'h01, {7'h0, group_b_irq_request});
      compare("irq a idle", 8'h00, {7'h0, group_a_irq_request});
      compare("b lines", 8'h04, {5'h0, pc_oe_n[2:0]});
      rd_chk("latched b", IDX_PB, d);
      d = 8'($urandom);
      peer.send(1'b0, d);
      wait_pc(PC_IBF_A);
      compare("irq a both", 8'h01, {7'h0, group_a_irq_request});
      rd_chk("latched a3", IDX_PA, d);
      rd_chk("ctl both", IDX_CTL, 8'hB6);
      // group a strobed output, partner acknowledges the byte
      wr_reg(IDX_CTL, 8'hA0);
      wr_reg(IDX_CTL, 8'h0D);
      d = 8'($urandom);
      wr_reg(IDX_PA, d);
      repeat (2) @(posedge clk);
      compare("out a", d, pa_out);
      compare("out a oe", 8'h00, pa_oe_n);
      compare("out full a", 8'h00, {7'h0, pc_out[7]});
      peer.take();
      repeat (3) @(posedge clk);
      compare("out empty a", 8'h01, {7'h0, pc_out[7]});
      compare("irq a out", 8'h01, {7'h0, group_a_irq_request});
      wr_reg(IDX_PA, ~d);
      repeat (2) @(posedge clk);
      compare("irq a out off", 8'h00, {7'h0, group_a_irq_request});
      // bidirectional group a: port a drives only while ack is low
      wr_reg(IDX_CTL, 8'hC0);
      repeat (2) @(posedge clk);
      compare("bidir c oe", 8'h50, pc_oe_n);
      compare("bidir a oe", 8'hFF, pa_oe_n);
      peer.take();
      compare("bidir a drive", 8'h00, pa_oe_n);
      finish_test();
   end
endmodule
